// File: logic/pmrc_pkg.sv
// Shared constants for the power mode and reset control block
package pmrc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ               = 40;
  localparam int WAKE_SETTLE_TIME_US   = 200;
  localparam int UV_RESET_DELAY_US     = 1;
  // Times convert exactly to cycles; the UV reset delay never drops below one cycle
  localparam int WAKE_SETTLE_CYCLES    = WAKE_SETTLE_TIME_US * CLK_MHZ;
  localparam int UV_RESET_CYCLES_RAW   = UV_RESET_DELAY_US * CLK_MHZ;
  localparam int UV_RESET_CYCLES       = (UV_RESET_CYCLES_RAW < 1) ? 1 : UV_RESET_CYCLES_RAW;

  // ****************************************************************
  // Frame layout and reset values
  // ****************************************************************
  localparam int FRAME_W               = 16;
  localparam int CMD_WAKE_POS          = 0;
  localparam int STANDBY_COMMAND_BIT_POS           = 1;
  localparam int CMD_RST_POS           = 2;
  localparam int CHAN_W                = 8;
  localparam logic [7:0] CHAN_RESET    = 8'h00;
  localparam logic [7:0] DIAG_RESET    = 8'h00;
  localparam logic [15:0] BANK_RESET   = 16'h0000;

  // ****************************************************************
  // Power states
  // ****************************************************************
  typedef enum logic [2:0] {
    PM_RESET  = 3'h1,
    PM_SLEEP  = 3'h2,
    PM_ACTIVE = 3'h4
  } pmrc_state_t;

endpackage

// File: logic/pmrc_settle_timer.sv
// Down counter timing the wake settle interval
module pmrc_settle_timer #(
  parameter int CYCLES = 8000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic start,
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (start) begin
      cnt_d = CW'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);

endmodule

// File: logic/pmrc_top.sv
// Power state, undervoltage and command reset control
// What this block does
// RULE1 - After supply start, registers hold defaults and the device sleeps.
// RULE2 - A frame with the wake bit set moves sleep to active.
// RULE3 - A frame with the standby bit set moves active back to sleep.
// RULE4 - Host sends no frame during the wake settle time after waking.
// RULE5 - Frames arriving during the wake settle interval are discarded.
// RULE6 - Shift path and daisy chain pass-through work whenever logic supply is good.
// RULE7 - Entering sleep clears the register banks to defaults.
// RULE8 - Sleep changes only by command bits or loss of logic supply; here battery supply loss also forces reset.
// RULE9 - Any reset turns all channels off and restores register defaults.
// RULE10 - After any reset the frame error flag is set and the device sleeps.
// RULE11 - In undervoltage reset with good logic supply, reads return flagged diagnostic frame.
// RULE12 - Undervoltage reset releases only when both supplies are good.
// RULE13 - Reset command bit clears register banks and diagnosis registers at once.
// RULE14 - Undervoltage on either supply asserts reset within one microsecond.
// RULE15 - Reset bit beats wake or standby in the same frame; device sleeps.
module pmrc_top #(
  parameter int WAKE_SETTLE_CYCLES = pmrc_pkg::WAKE_SETTLE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        battery_supply_ok,
  input  wire logic        logic_supply_ok,
  input  wire logic        frame_valid,
  input  wire logic [15:0] frame_data,
  input  wire logic        chain_in,
  input  wire logic [15:0] bank_write_data,
  input  wire logic        bank_write,
  input  wire logic [7:0]  diag_events,
  input  wire logic        error_flag_clear,
  output logic             chain_out,
  output logic             active_mode,
  output logic             in_uv_reset,
  output logic             settle_busy,
  output logic             frame_error_flag,
  output logic [7:0]       channel_on,
  output logic [15:0]      bank_q,
  output logic [7:0]       diag_q,
  output logic [15:0]      read_frame,
  output logic             frame_taken,
  output logic             frame_dropped
);

  // ****************************************************************
  // Reset release and pin synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [1:0] bat_sync_q;
  logic [1:0] log_sync_q;
  logic [1:0] chain_sync_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bat_sync_q   <= 2'h0;
      log_sync_q   <= 2'h0;
      chain_sync_q <= 2'h0;
    end else begin
      bat_sync_q   <= {bat_sync_q[0], battery_supply_ok};
      log_sync_q   <= {log_sync_q[0], logic_supply_ok};
      chain_sync_q <= {chain_sync_q[0], chain_in};
    end
  end

  logic bat_ok;
  logic log_ok;
  assign bat_ok = bat_sync_q[1];
  assign log_ok = log_sync_q[1];

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  logic cmd_wake;
  logic standby_command_bit;
  logic cmd_rst;
  logic uv_now;
  assign cmd_wake = frame_data[pmrc_pkg::CMD_WAKE_POS];
  assign standby_command_bit  = frame_data[pmrc_pkg::STANDBY_COMMAND_BIT_POS];
  assign cmd_rst  = frame_data[pmrc_pkg::CMD_RST_POS];
  // Undervoltage reset held until both supplies good; synchroniser delay 2 cycles < 1 us
  assign uv_now   = !(bat_ok && log_ok); // RULE12 RULE14

  logic busy;
  logic accept;
  assign accept = frame_valid && log_ok && !busy && !uv_now; // RULE5

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  pmrc_pkg::pmrc_state_t state_q;
  pmrc_pkg::pmrc_state_t state_d;
  logic                  reset_event;
  logic                  wake_go;
  logic                  stb_go;
  logic                  wake_start;

  // Reset from the supplies or from the command bit
  assign reset_event = uv_now || (accept && cmd_rst); // RULE9 RULE13
  // Reset bit wins over wake and standby in the same frame
  assign wake_go     = accept && cmd_wake && !cmd_rst; // RULE15
  assign stb_go      = accept && standby_command_bit && !cmd_rst; // RULE15
  assign wake_start  = wake_go && (state_q == pmrc_pkg::PM_SLEEP); // RULE2

  always_comb begin
    state_d = state_q;
    case (state_q)
      pmrc_pkg::PM_RESET: begin
        if (!uv_now) begin
          state_d = pmrc_pkg::PM_SLEEP; // RULE1 RULE10
        end
      end
      pmrc_pkg::PM_SLEEP: begin
        if (wake_go) begin
          state_d = pmrc_pkg::PM_ACTIVE; // RULE2 RULE8
        end
      end
      pmrc_pkg::PM_ACTIVE: begin
        if (stb_go) begin
          state_d = pmrc_pkg::PM_SLEEP; // RULE3 RULE8
        end
      end
      default: begin
        state_d = pmrc_pkg::PM_RESET;
      end
    endcase
    if (uv_now) begin
      state_d = pmrc_pkg::PM_RESET; // RULE12 RULE14
    end else if (accept && cmd_rst) begin
      state_d = pmrc_pkg::PM_SLEEP; // RULE10 RULE15
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmrc_pkg::PM_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Wake settle timer
  // ****************************************************************
  pmrc_settle_timer #(
    .CYCLES(WAKE_SETTLE_CYCLES)
  ) u_settle (
    .clock(clock),
    .rst_n(rst_n),
    .clear(reset_event),
    .start(wake_start),
    .busy (busy)
  );

  // ****************************************************************
  // Channels, register bank, diagnosis and error flag
  // ****************************************************************
  logic [7:0]  chan_d;
  logic [15:0] bank_d;
  logic [7:0]  diag_d;
  logic        flag_d;
  logic        plain_frame;

  // Frame without command bits carries channel settings
  assign plain_frame = accept && !cmd_wake && !standby_command_bit && !cmd_rst;

  always_comb begin
    chan_d = channel_on;
    bank_d = bank_q;
    diag_d = diag_q | diag_events;
    flag_d = frame_error_flag;
    if (error_flag_clear) begin
      flag_d = 1'b0;
    end
    if (reset_event) begin
      chan_d = pmrc_pkg::CHAN_RESET; // RULE9
      bank_d = pmrc_pkg::BANK_RESET; // RULE9 RULE13
      diag_d = pmrc_pkg::DIAG_RESET; // RULE13
      flag_d = 1'b1; // RULE10
    end else if ((state_q != pmrc_pkg::PM_ACTIVE) || stb_go) begin
      chan_d = pmrc_pkg::CHAN_RESET; // RULE7
      bank_d = pmrc_pkg::BANK_RESET; // RULE7
    end else begin
      if (bank_write) begin
        bank_d = bank_write_data;
      end
      if (plain_frame) begin
        chan_d = frame_data[15:8];
      end
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  logic        active_d;
  logic        uv_d;
  logic        busy_d;
  logic        taken_d;
  logic        dropped_d;
  logic        chain_d;
  logic [15:0] read_d;

  always_comb begin
    active_d  = (state_d == pmrc_pkg::PM_ACTIVE);
    uv_d      = uv_now;
    busy_d    = busy;
    taken_d   = accept;
    dropped_d = frame_valid && !accept; // RULE5
    chain_d   = 1'b0;
    if (log_ok) begin
      chain_d = chain_sync_q[1]; // RULE6
    end
    // Diagnostic frame: flag on top, diagnosis in the low byte
    read_d    = {frame_error_flag, 7'h00, diag_q}; // RULE11
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      channel_on       <= pmrc_pkg::CHAN_RESET; // RULE1
      bank_q           <= pmrc_pkg::BANK_RESET; // RULE1
      diag_q           <= pmrc_pkg::DIAG_RESET;
      frame_error_flag <= 1'b1; // RULE10
      active_mode      <= 1'b0;
      in_uv_reset      <= 1'b1;
      settle_busy      <= 1'b0;
      frame_taken      <= 1'b0;
      frame_dropped    <= 1'b0;
      chain_out        <= 1'b0;
      read_frame       <= 16'h8000;
    end else begin
      channel_on       <= chan_d;
      bank_q           <= bank_d;
      diag_q           <= diag_d;
      frame_error_flag <= flag_d;
      active_mode      <= active_d;
      in_uv_reset      <= uv_d;
      settle_busy      <= busy_d;
      frame_taken      <= taken_d;
      frame_dropped    <= dropped_d;
      chain_out        <= chain_d;
      read_frame       <= read_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_uv_forces_reset: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
    uv_now |=> (state_q == pmrc_pkg::PM_RESET))
    else $error("undervoltage did not enter reset");

  a_wake_to_active: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    (wake_start && !uv_now) |=> (state_q == pmrc_pkg::PM_ACTIVE))
    else $error("wake command did not reach active");

  a_stb_to_sleep: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    (stb_go && !cmd_wake && (state_q == pmrc_pkg::PM_ACTIVE))
    |=> (state_q == pmrc_pkg::PM_SLEEP))
    else $error("standby command did not reach sleep");

  a_reset_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
    reset_event |=> frame_error_flag)
    else $error("frame error flag not set after reset");

  a_reset_clears_all: assert property (@(posedge clock) disable iff (!rst_n) // RULE9 RULE13
    reset_event |=> ((channel_on == pmrc_pkg::CHAN_RESET)
                     && (bank_q == pmrc_pkg::BANK_RESET)
                     && (diag_q == pmrc_pkg::DIAG_RESET)))
    else $error("reset left state behind");

  a_drop_in_settle: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    (frame_valid && busy) |=> !frame_taken)
    else $error("frame taken during settle time");

  a_rst_beats_wake: assert property (@(posedge clock) disable iff (!rst_n) // RULE15
    (accept && cmd_rst) |=> (state_q == pmrc_pkg::PM_SLEEP))
    else $error("reset command did not end in sleep");

  a_sleep_clears_bank: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    (stb_go && (state_q == pmrc_pkg::PM_ACTIVE)) |=> (bank_q == pmrc_pkg::BANK_RESET))
    else $error("bank not cleared on sleep entry");

  a_chain_follow: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    log_ok |=> (chain_out == $past(chain_sync_q[1])))
    else $error("chain output does not follow input");

endmodule

// File: dv/pmrc_host.sv
// Host model that sends command frames to the block
module pmrc_host (
  input  wire logic   clock,
  output logic        frame_valid,
  output logic [15:0] frame_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    frame_valid = 1'b0;
    frame_data  = 16'h0000;
  end
  // One frame for one cycle, then idle lines flip and the host keeps quiet
  task automatic send(input logic [15:0] d, input int gap);
    @(posedge clock);
    #2;
    frame_valid = 1'b1;
    frame_data  = d;
    @(posedge clock);
    #2;
    frame_valid = 1'b0;
    frame_data  = ~d;
    repeat (gap) @(posedge clock);
  endtask
endmodule

// File: dv/pmrc_top_tb.sv
// Self-checking bench for the power mode and reset control block
module pmrc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ST = 20;
  logic clock = 1'b0, reset_n = 1'b0, bat = 1'b1, lgc = 1'b1, chain_in = 1'b0;
  logic bank_write = 1'b0, error_flag_clear = 1'b0, frame_valid;
  logic [15:0] frame_data, bank_write_data = 16'h0000, bank_q, read_frame;
  logic [7:0] diag_events = 8'h00, channel_on, diag_q;
  logic chain_out, active_mode, in_uv_reset, settle_busy, frame_error_flag;
  logic frame_taken, frame_dropped;
  int num_errors = 0, total_checks = 0, cycles = 0, taken_n = 0, dropped_n = 0;
  always @(posedge clock) begin
    if (frame_taken === 1'b1) taken_n++;
    if (frame_dropped === 1'b1) dropped_n++;
  end
  always #12.5 clock = ~clock;
  pmrc_host host (.clock(clock), .frame_valid(frame_valid), .frame_data(frame_data));
  pmrc_top #(.WAKE_SETTLE_CYCLES(ST)) dut (.clock(clock), .reset_n(reset_n),
    .battery_supply_ok(bat), .logic_supply_ok(lgc), .frame_valid(frame_valid),
    .frame_data(frame_data), .chain_in(chain_in), .bank_write_data(bank_write_data),
    .bank_write(bank_write), .diag_events(diag_events), .error_flag_clear(error_flag_clear),
    .chain_out(chain_out), .active_mode(active_mode), .in_uv_reset(in_uv_reset),
    .settle_busy(settle_busy), .frame_error_flag(frame_error_flag), .channel_on(channel_on),
    .bank_q(bank_q), .diag_q(diag_q), .read_frame(read_frame), .frame_taken(frame_taken),
    .frame_dropped(frame_dropped));
  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(19497));
    tick(3);
    reset_n = 1'b1;
    tick(4);
    chk("sleep", 16'h0000, 16'(active_mode));
    chk("flag", 16'h0001, 16'(frame_error_flag));
    chk("chan", 16'h0000, 16'(channel_on));
    chk("bank0", 16'h0000, bank_q);
    error_flag_clear = 1'b1;
    diag_events = 8'($urandom);
    chain_in = 1'($urandom);
    tick(1);
    error_flag_clear = 1'b0;
    diag_events = 8'h00;
    tick(2);
    chk("flagclr", 16'h0000, 16'(frame_error_flag));
    chk("chain", 16'(chain_in), 16'(chain_out));
    host.send(16'h0001, 2);
    chk("wake", 16'h0001, 16'(active_mode));
    chk("busy", 16'h0001, 16'(settle_busy));
    tick(ST);
    bank_write_data = 16'($urandom);
    bank_write = 1'b1;
    tick(1);
    bank_write = 1'b0;
    chk("bankwr", bank_write_data, bank_q);
    host.send(16'h0002, 3);
    chk("stb", 16'h0000, 16'(active_mode));
    chk("bank", 16'h0000, bank_q);
    host.send(16'h0001, 2);
    host.send(16'h0002, ST + 3);
    chk("drop", 16'h0001, 16'(active_mode));
    host.send(16'h0005, 3);
    chk("rstact", 16'h0000, 16'(active_mode));
    chk("rstflag", 16'h0001, 16'(frame_error_flag));
    chk("diag", 16'h0000, 16'(diag_q));
    bat = 1'b0;
    tick(40);
    chk("uv", 16'h0001, 16'(in_uv_reset));
    chk("uvread", 16'h8000, read_frame);
    lgc = 1'b0;
    bat = 1'b1;
    tick(4);
    chk("uvhold", 16'h0001, 16'(in_uv_reset));
    lgc = 1'b1;
    tick(8);
    chk("uvrel", 16'h0000, 16'(in_uv_reset));
    chk("uvflag", 16'h0001, 16'(frame_error_flag));
    chk("uvsleep", 16'h0000, 16'(active_mode));
    chk("taken", 16'h0004, 16'(taken_n));
    chk("dropped", 16'h0001, 16'(dropped_n));
    print_verdict();
  end
endmodule
